// File: rpas_top.v
// Host access port: pointer-based packet RAM access and second setup register
`timescale 1ns/1ps
`default_nettype none
`include "rpas_consts.vh"
module rpas_top #(
	parameter integer RECON0_CYC = `RPAS_RECON0_US * `RPAS_CLK_MHZ,
	parameter integer RECON1_CYC = `RPAS_RECON1_US * `RPAS_CLK_MHZ,
	parameter integer RECON2_CYC = `RPAS_RECON2_US * `RPAS_CLK_MHZ,
	parameter integer RECON3_CYC = `RPAS_RECON3_US * `RPAS_CLK_MHZ
) (
	input  wire                    core_clk,                // 200 MHz clock
	input  wire                    reset,                   // Synchronous reset, active high
	input  wire [`RPAS_ADDR_W-1:0] host_addr,               // Register offset pins
	input  wire [7:0]              host_data_in,            // Data bus, input side
	output reg  [7:0]              host_data_out,           // Data bus, output side
	output wire                    host_data_oe,            // High while driving data bus
	input  wire                    host_rd_n,               // Read strobe, active low
	input  wire                    host_wr_n,               // Write strobe, active low
	output wire                    host_wait,               // High while posted-write FIFO full
	input  wire                    fast_bus_timing_pin,     // External fast bus timing pin
	output wire                    fast_read_enable,        // Fast host read cycles allowed
	output wire                    clock_doubler_select,    // Core at 40 MHz when high
	output reg                     core_tick,               // Core-rate enable pulse
	output wire                    core_halted,             // Core stopped awaiting restart
	output wire                    enhanced_feature_enable, // Enhanced functions on
	output wire                    init_sync_disable,       // Sync command suppressed
	output wire                    init_sync_enable,        // Issue sync during init
	output wire                    idle_line_required,      // Idle line needed for RAM init
	output wire [1:0]              reconfig_timeout_select, // Reconfiguration timer field
	input  wire                    reconfig_start,          // Start reconfiguration timer
	output reg                     reconfig_expired,        // Timeout pulse
	output wire [7:0]              first_setup_config,      // First setup register value
	output wire                    slow_arbitration         // Arbitration clock halved
);
	localparam [`RPAS_TMR_W-1:0] RC0 = RECON0_CYC[`RPAS_TMR_W-1:0];
	localparam [`RPAS_TMR_W-1:0] RC1 = RECON1_CYC[`RPAS_TMR_W-1:0];
	localparam [`RPAS_TMR_W-1:0] RC2 = RECON2_CYC[`RPAS_TMR_W-1:0];
	localparam [`RPAS_TMR_W-1:0] RC3 = RECON3_CYC[`RPAS_TMR_W-1:0];
	// Divider counts are cut to the counter width on purpose
	localparam integer           DIV_BASE_I = `RPAS_DIV_BASE;
	localparam integer           DIV_DBL_I  = `RPAS_DIV_DBL;
	localparam [3:0]             DIV_BASE = DIV_BASE_I[3:0];
	localparam [3:0]             DIV_DBL  = DIV_DBL_I[3:0];
	localparam integer           FW = `RPAS_RAM_AW + 8;

	function is_reg;
		input [`RPAS_ADDR_W-1:0] a;
		input [`RPAS_ADDR_W-1:0] off;
		begin
			is_reg = (a == off);
		end
	endfunction

	// Host pins are asynchronous to core_clk
	// Strobes get a third stage so each edge detector sees a settled old value
	reg [`RPAS_ADDR_W-1:0] addr_s1_q;
	reg [`RPAS_ADDR_W-1:0] addr_s2_q;
	reg [7:0]              data_s1_q;
	reg [7:0]              data_s2_q;
	reg                    rd_s1_q;
	reg                    rd_s2_q;
	reg                    rd_s3_q;
	reg                    wr_s1_q;
	reg                    wr_s2_q;
	reg                    wr_s3_q;
	reg                    pin_s1_q;
	reg                    pin_s2_q;

	always @(posedge core_clk) begin
		if (reset) begin
			addr_s1_q <= {`RPAS_ADDR_W{1'b0}};
			addr_s2_q <= {`RPAS_ADDR_W{1'b0}};
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
			rd_s1_q   <= 1'b1;
			rd_s2_q   <= 1'b1;
			rd_s3_q   <= 1'b1;
			wr_s1_q   <= 1'b1;
			wr_s2_q   <= 1'b1;
			wr_s3_q   <= 1'b1;
			pin_s1_q  <= 1'b0;
			pin_s2_q  <= 1'b0;
		end else begin
			addr_s1_q <= host_addr;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= host_data_in;
			data_s2_q <= data_s1_q;
			rd_s1_q   <= host_rd_n;
			rd_s2_q   <= rd_s1_q;
			rd_s3_q   <= rd_s2_q;
			wr_s1_q   <= host_wr_n;
			wr_s2_q   <= wr_s1_q;
			wr_s3_q   <= wr_s2_q;
			pin_s1_q  <= fast_bus_timing_pin;
			pin_s2_q  <= pin_s1_q;
		end
	end

	wire wr_ev  = ~wr_s2_q & wr_s3_q;
	// Read side effects wait for the strobe to end, so the byte stays stable on the bus
	wire rd_end = rd_s2_q & ~rd_s3_q;

	// Decodes read the synced address, which stands around each strobe
	wire wr_upper = wr_ev & is_reg(addr_s2_q, `RPAS_OFF_PTR_UPPER);
	wire wr_lower = wr_ev & is_reg(addr_s2_q, `RPAS_OFF_PTR_LOWER);
	wire wr_data  = wr_ev & is_reg(addr_s2_q, `RPAS_OFF_DATA);
	wire wr_s1reg = wr_ev & is_reg(addr_s2_q, `RPAS_OFF_FIRST_SETUP_CONFIG);
	wire wr_s2reg = wr_ev & is_reg(addr_s2_q, `RPAS_OFF_SETUP2);
	wire wr_cmd   = wr_ev & is_reg(addr_s2_q, `RPAS_OFF_COMMAND);
	wire rd_data  = rd_end & is_reg(addr_s2_q, `RPAS_OFF_DATA);

	reg  [7:0]                upper_q;
	reg  [`RPAS_RAM_AW-1:0]   ptr_q;
	reg  [7:0]                first_setup_config_q;
	reg  [7:0]                setup2_q;
	reg  [7:0]                hold_q;
	reg                       fetch_pend_q;
	reg                       rd_infl_q;
	reg                       halted_q;
	reg                       arb_div_q;
	// Auto-increment sits in the top bit of the upper pointer; bits 6:3 are only stored
	wire                      auto_inc = upper_q[`RPAS_AUTOINC_BIT];
	wire [`RPAS_RAM_AW-1:0]   ptr_inc  = ptr_q + 1'b1;
	wire [`RPAS_RAM_AW-1:0]   load_ptr = {upper_q[`RPAS_RAM_AW-9:0], data_s2_q};
	// Reserved setup bits are stored as zero so readback never shows junk
	wire [7:0]                s2_wr    = data_s2_q & ~`RPAS_S2_RSVD_MASK;

	wire                      fifo_in_ready;
	wire                      fifo_out_valid;
	wire [FW-1:0]             fifo_out_data;
	wire                      fifo_pop;
	wire [7:0]                ram_rdata;
	wire                      arb_en;
	wire                      arb_go;
	wire                      ram_re;

	// Host must hold data writes while this is high; a refused byte is lost
	assign host_wait = ~fifo_in_ready;
	// A refused write must not move the pointer, or the readback miscounts transfers
	wire   wr_data_ok = wr_data & fifo_in_ready;

	// Posted writes carry their own address, so the pointer may run ahead of the RAM
	rpas_fifo #(
		.WIDTH (FW),
		.DEPTH (`RPAS_FIFO_DEPTH),
		.AW    (`RPAS_FIFO_AW)
	) u_fifo (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (wr_data),
		.in_ready  (fifo_in_ready),
		.in_data   ({ptr_q, data_s2_q}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// Arbitration slot every cycle, or every second cycle when slowed
	assign slow_arbitration = first_setup_config_q[`RPAS_SLOWARB_BIT];
	assign arb_en = slow_arbitration ? arb_div_q : 1'b1;
	assign arb_go = arb_en & ~halted_q;
	// Pending writes drain before any prefetch so a read never overtakes a write
	assign fifo_pop = arb_go & fifo_out_valid;
	assign ram_re   = arb_go & ~fifo_out_valid & fetch_pend_q & ~rd_infl_q;

	rpas_ram #(
		.AW    (`RPAS_RAM_AW),
		.DEPTH (`RPAS_RAM_DEPTH)
	) u_ram (
		.core_clk (core_clk),
		.we       (fifo_pop),
		.re       (ram_re),
		.addr     (fifo_pop ? fifo_out_data[FW-1:8] : ptr_q),
		.wdata    (fifo_out_data[7:0]),
		.rdata    (ram_rdata)
	);

	always @(posedge core_clk) begin
		if (reset) begin
			upper_q      <= `RPAS_UPPER_RST;
			ptr_q        <= {`RPAS_RAM_AW{1'b0}};
			first_setup_config_q     <= `RPAS_FIRST_SETUP_CONFIG_RST;
			setup2_q     <= `RPAS_SETUP2_RST;
			fetch_pend_q <= 1'b0;
			rd_infl_q    <= 1'b0;
			hold_q       <= 8'h00;
			arb_div_q    <= 1'b0;
		end else begin
			arb_div_q <= ~arb_div_q;
			rd_infl_q <= ram_re;
			if (rd_infl_q) begin
				hold_q <= ram_rdata;
			end
			if (wr_upper) begin
				upper_q <= data_s2_q;
			end
			if (wr_s1reg) begin
				first_setup_config_q <= data_s2_q;
			end
			if (wr_s2reg) begin
				setup2_q <= s2_wr;
			end
			// A new load in the same cycle as a fetch issue keeps the request alive
			if (wr_lower) begin
				ptr_q        <= load_ptr;
				fetch_pend_q <= 1'b1;
			end else if (rd_data && auto_inc) begin
				ptr_q        <= ptr_inc;
				fetch_pend_q <= 1'b1;
			end else begin
				if (wr_data_ok && auto_inc) begin
					ptr_q <= ptr_inc;
				end
				if (ram_re) begin
					fetch_pend_q <= 1'b0;
				end
			end
		end
	end

	// Core halt after a doubler change; restart command clears it, the change wins
	wire doubler_change = wr_s2reg &
		(s2_wr[`RPAS_S2_DOUBLER_BIT] != setup2_q[`RPAS_S2_DOUBLER_BIT]);
	wire restart_cmd = wr_cmd & (data_s2_q == `RPAS_CMD_RESTART);

	always @(posedge core_clk) begin
		if (reset) begin
			halted_q <= 1'b0;
		end else if (doubler_change) begin
			halted_q <= 1'b1;
		end else if (restart_cmd) begin
			halted_q <= 1'b0;
		end
	end

	assign core_halted = halted_q;

	// Core-rate enable: 20 MHz or 40 MHz out of the 200 MHz clock
	// The counter parks at zero while halted, so the first tick follows restart by a full period
	reg  [3:0] tick_cnt_q;
	wire [3:0] tick_div = clock_doubler_select ? DIV_DBL : DIV_BASE;

	always @(posedge core_clk) begin
		if (reset) begin
			tick_cnt_q <= 4'h0;
			core_tick  <= 1'b0;
		end else if (halted_q) begin
			tick_cnt_q <= 4'h0;
			core_tick  <= 1'b0;
		end else if (tick_cnt_q >= tick_div - 4'h1) begin
			tick_cnt_q <= 4'h0;
			core_tick  <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 4'h1;
			core_tick  <= 1'b0;
		end
	end

	assign fast_read_enable        = pin_s2_q & setup2_q[`RPAS_S2_FASTRD_BIT];
	assign clock_doubler_select    = setup2_q[`RPAS_S2_DOUBLER_BIT];
	assign enhanced_feature_enable = setup2_q[`RPAS_S2_ENH_BIT];
	assign init_sync_disable       = setup2_q[`RPAS_S2_INIT_SYNC_DISABLE_BIT];
	assign init_sync_enable        = ~init_sync_disable;
	assign idle_line_required      = ~init_sync_disable;
	assign reconfig_timeout_select = setup2_q[`RPAS_S2_RECON_HI:`RPAS_S2_RECON_LO];
	assign first_setup_config      = first_setup_config_q;

	// Reconfiguration timer; the period is latched at start
	// Periods count core_clk cycles; a test may shorten them through the parameters
	reg [`RPAS_TMR_W-1:0] recon_cnt_q;
	reg [`RPAS_TMR_W-1:0] recon_len;

	always @* begin
		case (reconfig_timeout_select)
			2'b00:   recon_len = RC0;
			2'b01:   recon_len = RC1;
			2'b10:   recon_len = RC2;
			default: recon_len = RC3;
		endcase
	end

	always @(posedge core_clk) begin
		if (reset) begin
			recon_cnt_q      <= {`RPAS_TMR_W{1'b0}};
			reconfig_expired <= 1'b0;
		end else if (reconfig_start) begin
			recon_cnt_q      <= recon_len;
			reconfig_expired <= 1'b0;
		end else if (recon_cnt_q != {`RPAS_TMR_W{1'b0}}) begin
			recon_cnt_q      <= recon_cnt_q - 1'b1;
			reconfig_expired <= (recon_cnt_q == {{(`RPAS_TMR_W-1){1'b0}}, 1'b1});
		end else begin
			reconfig_expired <= 1'b0;
		end
	end

	// Read mux; reserved setup bits always read as zero
	// Unused offsets 0 and 7 read as zero and ignore writes
	always @(posedge core_clk) begin
		if (reset) begin
			host_data_out <= 8'h00;
		end else if (is_reg(addr_s2_q, `RPAS_OFF_PTR_UPPER)) begin
			host_data_out <= {upper_q[7:`RPAS_RAM_AW-8], ptr_q[`RPAS_RAM_AW-1:8]};
		end else if (is_reg(addr_s2_q, `RPAS_OFF_PTR_LOWER)) begin
			host_data_out <= ptr_q[7:0];
		end else if (is_reg(addr_s2_q, `RPAS_OFF_DATA)) begin
			host_data_out <= hold_q;
		end else if (is_reg(addr_s2_q, `RPAS_OFF_FIRST_SETUP_CONFIG)) begin
			host_data_out <= first_setup_config_q;
		end else if (is_reg(addr_s2_q, `RPAS_OFF_SETUP2)) begin
			host_data_out <= setup2_q;
		end else begin
			host_data_out <= 8'h00;
		end
	end

	assign host_data_oe = ~rd_s2_q;
endmodule // rpas_top
`default_nettype wire

// File: rpas_consts.vh
// Register offsets, field positions, reset values and timing counts for the RAM pointer block
`ifndef RPAS_CONSTS_VH
`define RPAS_CONSTS_VH

`define RPAS_ADDR_W          3
`define RPAS_OFF_COMMAND     3'h1
`define RPAS_OFF_PTR_UPPER   3'h2
`define RPAS_OFF_PTR_LOWER   3'h3
`define RPAS_OFF_DATA        3'h4
`define RPAS_OFF_FIRST_SETUP_CONFIG      3'h5
`define RPAS_OFF_SETUP2      3'h6

`define RPAS_RAM_AW          11
`define RPAS_RAM_DEPTH       2048
`define RPAS_FIFO_DEPTH      16
`define RPAS_FIFO_AW         4

`define RPAS_AUTOINC_BIT     7
`define RPAS_SLOWARB_BIT     0
`define RPAS_S2_FASTRD_BIT   7
`define RPAS_S2_RSVD_MASK    8'h60
`define RPAS_S2_DOUBLER_BIT  4
`define RPAS_S2_ENH_BIT      3
`define RPAS_S2_INIT_SYNC_DISABLE_BIT   2
`define RPAS_S2_RECON_HI     1
`define RPAS_S2_RECON_LO     0

`define RPAS_FIRST_SETUP_CONFIG_RST      8'h00
`define RPAS_SETUP2_RST      8'h00
`define RPAS_UPPER_RST       8'h00
`define RPAS_CMD_RESTART     8'h18

`define RPAS_CLK_MHZ         200
`define RPAS_CORE_MHZ_BASE   20
`define RPAS_CORE_MHZ_DBL    40
`define RPAS_DIV_BASE        (`RPAS_CLK_MHZ / `RPAS_CORE_MHZ_BASE)
`define RPAS_DIV_DBL         (`RPAS_CLK_MHZ / `RPAS_CORE_MHZ_DBL)

`define RPAS_RECON0_US       420000
`define RPAS_RECON1_US       105000
`define RPAS_RECON2_US       52500
`define RPAS_RECON3_US       26250
`define RPAS_TMR_W           27

`endif

// File: rpas_ram.v
// Single-port 2K x 8 packet RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module rpas_ram #(
	parameter integer AW    = 11,
	parameter integer DEPTH = 2048
) (
	input  wire          core_clk, // System clock
	input  wire          we,       // Write strobe
	input  wire          re,       // Read strobe
	input  wire [AW-1:0] addr,     // Byte address
	input  wire [7:0]    wdata,    // Write byte
	output reg  [7:0]    rdata     // Read byte, valid the cycle after re
);
	reg [7:0] mem [0:DEPTH-1];

	always @(posedge core_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata <= mem[addr];
		end
	end
endmodule // rpas_ram
`default_nettype wire

// File: rpas_fifo.v
// Posted-write FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rpas_fifo #(
	parameter integer WIDTH = 19,
	parameter integer DEPTH = 16,
	parameter integer AW    = 4
) (
	input  wire             core_clk,  // System clock
	input  wire             reset,     // Synchronous reset, active high
	input  wire             in_valid,  // Push request
	output wire             in_ready,  // Not full
	input  wire [WIDTH-1:0] in_data,   // Push word
	output wire             out_valid, // Not empty
	input  wire             out_ready, // Pop request
	output wire [WIDTH-1:0] out_data   // Head word
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wptr_q;
	reg [AW:0]      rptr_q;
	wire            push;
	wire            pop;

	assign in_ready  = (wptr_q - rptr_q) != DEPTH[AW:0];
	assign out_valid = wptr_q != rptr_q;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rptr_q[AW-1:0]];

	always @(posedge core_clk) begin
		if (push) begin
			mem[wptr_q[AW-1:0]] <= in_data;
		end
		if (reset) begin
			wptr_q <= {(AW+1){1'b0}};
			rptr_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
		end
	end
endmodule // rpas_fifo
`default_nettype wire

// File: rpas_checker.sv
// Port-level assertions for the RAM pointer access block
`timescale 1ns/1ps
`default_nettype none
module rpas_checker #(
	parameter integer RECON0_CYC = 40,
	parameter integer RECON1_CYC = 20,
	parameter integer RECON2_CYC = 10,
	parameter integer RECON3_CYC = 5
) (
	input wire logic       core_clk,                // Clock
	input wire logic       reset,                   // Synchronous reset
	input wire logic       host_rd_n,               // Read strobe
	input wire logic       host_data_oe,            // Data bus drive
	input wire logic       fast_bus_timing_pin,     // Timing pin
	input wire logic       fast_read_enable,        // Fast reads on
	input wire logic       clock_doubler_select,    // Doubler bit
	input wire logic       core_tick,               // Core enable pulse
	input wire logic       core_halted,             // Awaiting restart
	input wire logic       enhanced_feature_enable, // Enhanced bit
	input wire logic       init_sync_disable,       // Sync disable bit
	input wire logic       init_sync_enable,        // Sync issued
	input wire logic       idle_line_required,      // Idle line needed
	input wire logic [1:0] reconfig_timeout_select, // Timer field
	input wire logic       reconfig_start,          // Timer start
	input wire logic       reconfig_expired,        // Timer end pulse
	input wire logic [7:0] first_setup_config,      // First setup value
	input wire logic       slow_arbitration         // Halved arbitration
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [31:0] cnt_q;
	logic [1:0]  sel_q;
	int          lim;
	// Period is latched at start so a later field write cannot blur the window
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_q <= 32'h0;
			sel_q <= 2'h0;
		end else if (reconfig_start) begin
			cnt_q <= 32'h1;
			sel_q <= reconfig_timeout_select;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end
	always_comb begin
		case (sel_q)
			2'h0: lim = RECON0_CYC;
			2'h1: lim = RECON1_CYC;
			2'h2: lim = RECON2_CYC;
			default: lim = RECON3_CYC;
		endcase
	end
	property p_fast_rd;
		!fast_bus_timing_pin [*4] |-> !fast_read_enable;
	endproperty
	a_fast_rd: assert property (p_fast_rd) else $error("fast read on with pin low");
	property p_tick_base;
		core_tick && !clock_doubler_select && !core_halted |=>
			!core_tick [*8] ##1 !core_tick ##1 (core_tick || core_halted || clock_doubler_select);
	endproperty
	a_tick_base: assert property (p_tick_base) else $error("base tick period wrong");
	property p_tick_dbl;
		core_tick && clock_doubler_select && !core_halted |=>
			!core_tick [*4] ##1 (core_tick || core_halted || !clock_doubler_select);
	endproperty
	a_tick_dbl: assert property (p_tick_dbl) else $error("doubled tick period wrong");
	property p_halt_tick;
		core_halted && $past(core_halted) |-> !core_tick;
	endproperty
	a_halt_tick: assert property (p_halt_tick) else $error("tick while halted");
	property p_halt_set;
		$changed(clock_doubler_select) |-> ##[0:1] core_halted;
	endproperty
	a_halt_set: assert property (p_halt_set) else $error("no halt after doubler change");
	property p_sync;
		init_sync_enable == !init_sync_disable && idle_line_required == !init_sync_disable;
	endproperty
	a_sync: assert property (p_sync) else $error("sync outputs disagree");
	property p_recon;
		reconfig_expired |-> cnt_q + 32'h1 >= lim && cnt_q <= lim + 1;
	endproperty
	a_recon: assert property (p_recon) else $error("timeout period wrong");
	property p_oe;
		(!host_rd_n [*4] |-> host_data_oe) and (host_rd_n [*4] |-> !host_data_oe);
	endproperty
	a_oe: assert property (p_oe) else $error("data drive not following read");
	property p_slow;
		slow_arbitration == first_setup_config[0];
	endproperty
	a_slow: assert property (p_slow) else $error("slow arbitration mismatch");
	property p_rst;
		$fell(reset) |-> reconfig_timeout_select == 2'h0 && !enhanced_feature_enable
			&& !init_sync_disable && !clock_doubler_select && !core_halted;
	endproperty
	a_rst: assert property (p_rst) else $error("setup not clear after reset");
	c_halt: cover property (core_halted);
	c_exp: cover property (reconfig_expired);
	c_fast: cover property (fast_read_enable);
	c_slow: cover property (slow_arbitration && host_data_oe);
endmodule // rpas_checker
bind rpas_top rpas_checker #(
	.RECON0_CYC(RECON0_CYC),
	.RECON1_CYC(RECON1_CYC),
	.RECON2_CYC(RECON2_CYC),
	.RECON3_CYC(RECON3_CYC)
) u_chk (
	.core_clk(core_clk), .reset(reset), .host_rd_n(host_rd_n), .host_data_oe(host_data_oe),
	.fast_bus_timing_pin(fast_bus_timing_pin), .fast_read_enable(fast_read_enable),
	.clock_doubler_select(clock_doubler_select), .core_tick(core_tick),
	.core_halted(core_halted), .enhanced_feature_enable(enhanced_feature_enable),
	.init_sync_disable(init_sync_disable), .init_sync_enable(init_sync_enable),
	.idle_line_required(idle_line_required), .reconfig_timeout_select(reconfig_timeout_select),
	.reconfig_start(reconfig_start), .reconfig_expired(reconfig_expired),
	.first_setup_config(first_setup_config), .slow_arbitration(slow_arbitration)
);
`default_nettype wire

// File: rpas_host.sv
// Host microcontroller model driving the parallel register pins
`timescale 1ns/1ps
`default_nettype none
module rpas_host #(
	parameter integer RESTART_WAIT = 20
) (
	input wire logic       core_clk,      // Clock
	input wire logic [7:0] host_data_out, // Read data
	input wire logic       host_data_oe,  // Read data driven
	output var logic [2:0] host_addr,     // Register offset
	output var logic [7:0] host_data_in,  // Write data
	output var logic       host_rd_n,     // Read strobe
	output var logic       host_wr_n,     // Write strobe
	output var logic       rd_done,       // One cycle per finished read
	output var logic [8:0] rd_byte        // Drive flag and byte seen
);
	initial begin
		host_addr = 3'h0;
		host_data_in = 8'h00;
		host_rd_n = 1'h1;
		host_wr_n = 1'h1;
		rd_done = 1'h0;
		rd_byte = 9'h000;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Pins are synced inside, so address and data stand well around the strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		cyc(1);
		host_addr = a;
		host_data_in = (a == 3'h6) ? (d & 8'h9F) : d;
		cyc(4);
		host_wr_n = 1'h0;
		cyc(5);
		host_wr_n = 1'h1;
		cyc(4);
		// Released bus shows no stale value
		host_data_in = ~host_data_in;
	endtask
	task automatic rd(input logic [2:0] a);
		cyc(1);
		host_addr = a;
		cyc(4);
		host_rd_n = 1'h0;
		cyc(6);
		rd_byte = {host_data_oe, host_data_out};
		rd_done = 1'h1;
		cyc(1);
		rd_done = 1'h0;
		host_rd_n = 1'h1;
		cyc(4);
	endtask
	// Interrupts are assumed masked by the caller across both writes
	task automatic ptr(input logic [7:0] up, input logic [7:0] lo);
		wr(3'h2, up);
		wr(3'h3, lo);
	endtask
	task automatic restart();
		cyc(RESTART_WAIT);
		wr(3'h1, 8'h18);
	endtask
endmodule // rpas_host
`default_nettype wire

// File: ram_pointer_access_setup_bench.sv
// Self-checking bench for the RAM pointer access block
`timescale 1ns/1ps
`default_nettype none
module ram_pointer_access_setup_bench;
	logic       core_clk = 1'h0;
	logic       reset = 1'h1;
	logic       fast_bus_timing_pin = 1'h0;
	logic       reconfig_start = 1'h0;
	wire  [2:0] host_addr;
	wire  [7:0] host_data_in, host_data_out, first_setup_config;
	wire        host_data_oe, host_rd_n, host_wr_n, host_wait, fast_read_enable;
	wire        clock_doubler_select, core_tick, core_halted, enhanced_feature_enable;
	wire        init_sync_disable, init_sync_enable, idle_line_required;
	wire  [1:0] reconfig_timeout_select;
	wire        reconfig_expired, slow_arbitration, rd_done;
	wire  [8:0] rd_byte;
	int         errors = 0;
	int         checks_done = 0;
	int         rc[4] = '{40, 20, 10, 5};
	logic [31:0] seed = 32'h425C;
	logic [8:0]  expq[$];
	logic [7:0]  wb[17];
	logic [7:0]  v;
	always #2.5 core_clk = ~core_clk;
	rpas_top #(.RECON0_CYC(40), .RECON1_CYC(20), .RECON2_CYC(10), .RECON3_CYC(5)) u_dut (
		.core_clk(core_clk), .reset(reset), .host_addr(host_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
		.host_wait(host_wait), .fast_bus_timing_pin(fast_bus_timing_pin),
		.fast_read_enable(fast_read_enable), .clock_doubler_select(clock_doubler_select),
		.core_tick(core_tick), .core_halted(core_halted),
		.enhanced_feature_enable(enhanced_feature_enable),
		.init_sync_disable(init_sync_disable), .init_sync_enable(init_sync_enable),
		.idle_line_required(idle_line_required),
		.reconfig_timeout_select(reconfig_timeout_select), .reconfig_start(reconfig_start),
		.reconfig_expired(reconfig_expired), .first_setup_config(first_setup_config),
		.slow_arbitration(slow_arbitration));
	rpas_host u_host (
		.core_clk(core_clk), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.host_addr(host_addr), .host_data_in(host_data_in), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .rd_done(rd_done), .rd_byte(rd_byte));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function automatic void nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
	endfunction
	task automatic rd_exp(input logic [2:0] a, input logic [7:0] e);
		expq.push_back({1'h1, e});
		u_host.rd(a);
	endtask
	task automatic gap(input int exp);
		int n;
		n = 0;
		@(posedge core_tick);
		@(negedge core_clk);
		do begin
			@(negedge core_clk);
			n++;
		end while (core_tick !== 1'h1 && n < 40);
		check("tick_gap", n, exp);
	endtask
	task automatic recon(input int lim);
		int n;
		@(negedge core_clk) reconfig_start = 1'h1;
		@(negedge core_clk) reconfig_start = 1'h0;
		n = 1;
		while (reconfig_expired !== 1'h1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		check("recon_time", n >= lim - 1 && n <= lim + 1, 1);
	endtask
	always @(posedge core_clk)
		if (rd_done === 1'h1)
			check("read", rd_byte, expq.pop_front());
	initial begin
		#(5ns * 40000);
		errors++;
		test_done();
	end
	initial begin
		repeat (12) @(negedge core_clk);
		reset = 1'h0;
		u_host.cyc(2);
		rd_exp(3'h6, 8'h00);
		check("setup2_outs", {clock_doubler_select, enhanced_feature_enable, init_sync_disable,
			reconfig_timeout_select, fast_read_enable, core_halted}, 0);
		gap(10);
		// Doubler bit stays clear here: it may change only once
		for (int i = 0; i < 4; i++) begin
			nxt();
			v = {i[1], 3'h0, seed[3:2], i[1:0]};
			fast_bus_timing_pin = i[0];
			u_host.wr(3'h6, v);
			rd_exp(3'h6, v);
			check("fast_rd", fast_read_enable, v[7] & i[0]);
			check("enh", enhanced_feature_enable, v[3]);
			check("sync", {init_sync_disable, init_sync_enable, idle_line_required},
				{v[2], ~v[2], ~v[2]});
			check("recon_sel", reconfig_timeout_select, v[1:0]);
			recon(rc[i]);
		end
		u_host.ptr(8'h87, 8'hFE);
		for (int i = 0; i < 4; i++) begin
			nxt();
			wb[i] = seed[7:0];
			u_host.wr(3'h4, wb[i]);
		end
		rd_exp(3'h2, 8'h80);
		rd_exp(3'h3, 8'h02);
		u_host.ptr(8'h87, 8'hFE);
		for (int i = 0; i < 4; i++)
			rd_exp(3'h4, wb[i]);
		u_host.wr(3'h5, 8'h01);
		check("slow", {slow_arbitration, first_setup_config}, 9'h101);
		u_host.ptr(8'h87, 8'hFF);
		rd_exp(3'h4, wb[1]);
		rd_exp(3'h4, wb[2]);
		rd_exp(3'h7, 8'h00);
		u_host.wr(3'h6, 8'h10);
		check("halt", {core_halted, clock_doubler_select}, 2'h3);
		u_host.ptr(8'h80, 8'h10);
		// Halted core posts nothing to RAM, so the write queue fills and refuses
		for (int i = 0; i < 17; i++) begin
			nxt();
			wb[i] = seed[7:0];
			check("wait", host_wait, i == 16);
			u_host.wr(3'h4, wb[i]);
		end
		rd_exp(3'h3, 8'h20);
		u_host.restart();
		check("halt", core_halted, 0);
		gap(5);
		u_host.ptr(8'h80, 8'h10);
		for (int i = 0; i < 16; i++)
			rd_exp(3'h4, wb[i]);
		check("pending", expq.size(), 0);
		test_done();
	end
endmodule // ram_pointer_access_setup_bench
`default_nettype wire
